/* File: bench/iefl_checker.sv */
// assertions on the ports of iefl_top
// assumes one clock aclk and sync active-low reset aresetn
`timescale 1ns/1ps
module iefl_checker (
  // clock and reset
  input wire       aclk,
  input wire       aresetn,
  // bus handshakes
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  // causes
  input wire       spi_tx_empty_evt,
  input wire       uart_b_req,
  // requests
  input wire       timer2_vec_req_r,
  input wire [3:0] shared_vec_req_r,
  input wire       spi_tx_vec_req_r,
  input wire       uart_b_vec_req_r,
  input wire       watchdog_start_r,
  input wire       watchdog_refresh_r
);
  // ======
  // cycles since last write handshake
  reg [3:0] wcnt_r;
  always @(posedge aclk)
    if (!aresetn)
      wcnt_r <= 4'hf;
    else if (s_axi_awvalid && s_axi_awready)
      wcnt_r <= 4'h0;
    else if (wcnt_r != 4'hf)
      wcnt_r <= wcnt_r + 4'h1;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ======
  // properties
  rst_clear_a:
    assert property (disable iff (1'b0) !aresetn |=> !timer2_vec_req_r && !spi_tx_vec_req_r
      && shared_vec_req_r == 4'h0 && !uart_b_vec_req_r && !watchdog_start_r
      && !watchdog_refresh_r)
    else $error("outputs not cleared by reset");
  start_cause_a:
    assert property (watchdog_start_r |-> wcnt_r <= 4'h3)
    else $error("start without recent write");
  refresh_cause_a:
    assert property (watchdog_refresh_r |-> wcnt_r <= 4'h3)
    else $error("refresh without recent write");
  wdog_pulse_a:
    assert property (watchdog_start_r || watchdog_refresh_r
      |=> !watchdog_start_r && !watchdog_refresh_r)
    else $error("watchdog pulse too long");
  uart_cause_a:
    assert property (uart_b_vec_req_r |-> $past(uart_b_req))
    else $error("uart request without source");
  spitx_cause_a:
    assert property ($rose(spi_tx_vec_req_r) |-> $past(spi_tx_empty_evt, 2) || wcnt_r <= 4'h3)
    else $error("spi tx request without cause");
  wr_pair_a:
    assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
    else $error("write ready not paired");
  bvalid_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  rvalid_cause_a:
    assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
    else $error("rvalid without address");
endmodule // iefl_checker

bind iefl_top iefl_checker i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
  .spi_tx_empty_evt, .uart_b_req, .timer2_vec_req_r, .shared_vec_req_r,
  .spi_tx_vec_req_r, .uart_b_vec_req_r, .watchdog_start_r, .watchdog_refresh_r
);

/* File: bench/iefl_periph_model.sv */
// peripheral event sources and reload pin
// assumes events are one-cycle pulses on aclk
`timescale 1ns/1ps
module iefl_periph_model (
  // clock
  input wire      aclk,
  // pulses: 0 t2ov,1 adc,2 mac,3 i2c,4 spirx,5 spitx,6..9 units
  output reg [9:0] evt_r,
  // pin and level request
  output reg       reload_pin,
  output reg       uart_req
);
  initial begin
    evt_r = 10'h000;
    reload_pin = 1'b1;
    uart_req = 1'b0;
  end
  task pulse(input int n);
    @(posedge aclk);
    evt_r[n] <= 1'b1;
    @(posedge aclk);
    evt_r[n] <= 1'b0;
  endtask
  task reload_fall;
    @(posedge aclk);
    reload_pin <= 1'b0;
    repeat (8) @(posedge aclk);
    reload_pin <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
  task req_level(input logic v);
    uart_req <= v;
  endtask
endmodule // iefl_periph_model

/* File: bench/test_interrupt_enable_flag_logic.sv */
// self-checking bench for iefl_top
// assumes iefl_periph_model as event source
`timescale 1ns/1ps
`include "iefl_map.vh"
module test_interrupt_enable_flag_logic;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0]  s_axi_wstrb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  ex;
  logic [1:0]  r;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [9:0]  evt;
  wire  [3:0]  shv;
  wire         pin, ureq, t2v, stv, ubv, wst, wrf;
  int          errors, checks, n_st, n_rf;
  iefl_periph_model m (.aclk, .evt_r(evt), .reload_pin(pin), .uart_req(ureq));
  iefl_top i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer2_overflow_evt(evt[0]),
    .adc_pinchange_evt(evt[1]), .mac_overflow_evt(evt[2]), .i2c_evt(evt[3]),
    .spi_rx_overrun_evt(evt[4]), .spi_tx_empty_evt(evt[5]), .uart_b_req(ureq),
    .compare_unit0_irq(evt[6]), .compare_unit1_irq(evt[7]), .compare_unit2_irq(evt[8]),
    .compare_unit3_irq(evt[9]), .timer2_reload_input(pin), .timer2_vec_req_r(t2v),
    .shared_vec_req_r(shv), .spi_tx_vec_req_r(stv), .uart_b_vec_req_r(ubv),
    .watchdog_start_r(wst), .watchdog_refresh_r(wrf)
  );
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (wst) n_st <= n_st + 1;
    if (wrf) n_rf <= n_rf + 1;
  end
  // ======
  // bus tasks and compares
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tmo;
    errors++;
    $display("ERROR bus wait exp answer got none");
    tally_and_finish;
  endtask
  task wr(input [7:0] i, input [7:0] v);
    int k;
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 40) tmo;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input [7:0] i);
    int k;
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 40) tmo;
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask
  task rchk(input [7:0] i, input [7:0] e);
    rd(i);
    chk($sformatf("reg %h", i), {24'h0, e}, d);
  endtask
  // ======
  // main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`IEFL_IDX_REQ_FLAG, 8'h00);
    rchk(`IEFL_IDX_PERIPH_EN, 8'h00);
    rchk(`IEFL_IDX_UART_B_EN, 8'h00);
    rd(8'h00);
    chk("resp", `IEFL_RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
    wr(8'h00, 8'hff);
    chk("bresp", `IEFL_RESP_SLVERR, r);
    wr(`IEFL_IDX_GLOBAL_CTRL, 8'ha0);
    chk("bresp", `IEFL_RESP_OKAY, r);
    s_axi_wstrb <= 4'he;
    wr(`IEFL_IDX_GLOBAL_CTRL, 8'h00);
    s_axi_wstrb <= 4'hf;
    rchk(`IEFL_IDX_GLOBAL_CTRL, 8'ha0);
    wr(`IEFL_IDX_PERIPH_EN, 8'h3e);
    ex = 8'h00;
    for (int n = 0; n < 6; n++) begin
      m.pulse(n);
      ex[6-n] = 1'b1;
      rchk(`IEFL_IDX_REQ_FLAG, ex);
    end
    chk("vec", 32'h3f, {t2v, shv, stv});
    wr(`IEFL_IDX_REQ_FLAG, 8'hfd);
    rchk(`IEFL_IDX_REQ_FLAG, 8'h7c);
    wr(`IEFL_IDX_GLOBAL_CTRL, 8'h20);
    chk("vec", 32'h0, {t2v, shv, stv});
    wr(`IEFL_IDX_GLOBAL_CTRL, 8'ha0);
    m.reload_fall;
    rchk(`IEFL_IDX_REQ_FLAG, 8'h7c);
    wr(`IEFL_IDX_PERIPH_EN, 8'hbe);
    m.reload_fall;
    rchk(`IEFL_IDX_REQ_FLAG, 8'hfc);
    chk("t2v", 32'h1, t2v);
    wr(`IEFL_IDX_REQ_FLAG, 8'h00);
    wr(`IEFL_IDX_COMPARE_CFG, 8'h04);
    rchk(`IEFL_IDX_COMPARE_CFG, 8'h04);
    m.pulse(2);
    m.pulse(6);
    rchk(`IEFL_IDX_REQ_FLAG, 8'h00);
    m.pulse(8);
    m.pulse(3);
    rchk(`IEFL_IDX_REQ_FLAG, 8'h18);
    chk("shv", 32'h6, shv);
    wr(`IEFL_IDX_COMPARE_CFG, 8'h00);
    wr(`IEFL_IDX_PERIPH_EN, 8'h7e);
    repeat (4) @(posedge aclk);
    chk("start", 32'h1, n_st);
    rchk(`IEFL_IDX_PERIPH_EN, 8'h3e);
    rchk(`IEFL_IDX_WDOG_STAT, 8'h05);
    wr(`IEFL_IDX_PERIPH_EN, 8'h7e);
    repeat (4) @(posedge aclk);
    chk("refresh", 32'h0, n_rf);
    wr(`IEFL_IDX_GLOBAL_CTRL, 8'he0);
    wr(`IEFL_IDX_PERIPH_EN, 8'h7e);
    repeat (4) @(posedge aclk);
    chk("refresh", 32'h1, n_rf);
    wr(`IEFL_IDX_UART_B_EN, 8'hff);
    rchk(`IEFL_IDX_UART_B_EN, 8'h01);
    m.req_level(1'b1);
    repeat (3) @(posedge aclk);
    chk("ubv", 32'h1, ubv);
    wr(`IEFL_IDX_UART_B_EN, 8'h00);
    repeat (2) @(posedge aclk);
    chk("ubv", 32'h0, ubv);
    tally_and_finish;
  end
endmodule // test_interrupt_enable_flag_logic

/* File: logic/iefl_map.vh */
// register indices, field positions and reset values of the interrupt enable/flag block
// included by every design file of the block; definitions only
`ifndef IEFL_MAP_VH
`define IEFL_MAP_VH

// ==========================================================================
// register indices (byte address is four times the index)
`define IEFL_IDX_GLOBAL_CTRL   8'ha8
`define IEFL_IDX_REQ_FLAG      8'h91
`define IEFL_IDX_UART_B_EN     8'h9a
`define IEFL_IDX_PERIPH_EN     8'he8
`define IEFL_IDX_COMPARE_CFG   8'hc1
`define IEFL_IDX_WDOG_STAT     8'hc2

// ==========================================================================
// global control fields
`define IEFL_GLB_GATE          7
`define IEFL_GLB_ARM           6
`define IEFL_GLB_T2OV_EN       5

// ==========================================================================
// peripheral enable and request flag fields
`define IEFL_BIT_T2RELOAD      7
`define IEFL_BIT_WATCHDOG_START_REFRESH          6
`define IEFL_BIT_T2OV          6
`define IEFL_BIT_ADC           5
`define IEFL_BIT_MAC           4
`define IEFL_BIT_I2C           3
`define IEFL_BIT_SPIRX         2
`define IEFL_BIT_SPITX         1
`define IEFL_BIT_UART_B        0

// ==========================================================================
// reset values and bus answers
`define IEFL_RST_BYTE          8'h00
`define IEFL_RST_CFG           4'h0
`define IEFL_RESP_OKAY         2'b00
`define IEFL_RESP_SLVERR       2'b10

`endif

/* File: logic/iefl_pin_sync.v */
// three-stage synchroniser with agreement filter and falling-edge pulse
// assumes a single clock domain aclk and a synchronous active-low reset
`timescale 1ns/1ps
`include "iefl_map.vh"

module iefl_pin_sync (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // pin side
  input  wire pin_in,
  // logic side
  output reg  level_r,
  output reg  fall_r
);

  reg [2:0] stage_r;

  // ========================================================================
  // sync chain, level taken once stages two and three agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      stage_r <= 3'h7;
      level_r <= 1'b1;
      fall_r  <= 1'b0;
    end else begin
      stage_r <= {stage_r[1:0], pin_in};
      fall_r  <= 1'b0;
      if (stage_r[1] == stage_r[2]) begin
        level_r <= stage_r[2];
        fall_r  <= level_r & ~stage_r[2];
      end
    end
  end

endmodule // iefl_pin_sync

/* File: logic/iefl_top.v */
// interrupt enables, request flags and vector requests behind an AXI4-Lite slave
// assumes peripheral events are one-cycle pulses on aclk; reload input is a pin
//
// Operation
// RULE1 - enable bit 7 gates reload-input interrupt and its flag setting
// RULE2 - setting start/refresh bit starts watchdog or refreshes a running one
// RULE3 - refresh happens only when start/refresh write directly follows arm write
// RULE4 - start/refresh bit clears itself once start or refresh is done
// RULE5 - enable bits 5,4,3 gate ADC/pin-change, MAC overflow and I2C
// RULE6 - enable bits 2,1 gate SPI receive/overrun and SPI transmit empty
// RULE7 - third enable register bit 0 gates second UART; bits 7..1 unused
// RULE8 - four peripheral vectors are shared with four compare units
// RULE9 - compare mode on a unit hands its vector to that unit
// RULE10 - owned vector blocks the peripheral event even if enabled
// RULE11 - owned vector is requested by the compare unit output
// RULE12 - takeover is decided per compare unit independently
// RULE13 - software reads flags to find source and clears the serviced one
// RULE14 - flag bit 6 sets on timer 2 overflow
// RULE15 - flag bits 5..2 follow peripherals, or compare units 3..0 in compare mode
// RULE16 - flag bit 2 on SPI receive/overrun, bit 1 on SPI transmit empty
// RULE17 - global gate bit must be set for any request to reach the core
// RULE18 - software sets arm bit just before the start/refresh bit
// RULE19 - flags stay set until cleared; request is flag and enable and gate
// RULE20 - reset clears all enables and flags
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "iefl_map.vh"

module iefl_top (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // axi4-lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // peripheral event pulses and second uart level request
  input  wire        timer2_overflow_evt,
  input  wire        adc_pinchange_evt,
  input  wire        mac_overflow_evt,
  input  wire        i2c_evt,
  input  wire        spi_rx_overrun_evt,
  input  wire        spi_tx_empty_evt,
  input  wire        uart_b_req,
  // compare unit pulses
  input  wire        compare_unit0_irq,
  input  wire        compare_unit1_irq,
  input  wire        compare_unit2_irq,
  input  wire        compare_unit3_irq,
  // reload pin
  input  wire        timer2_reload_input,
  // vector requests to the core
  output reg         timer2_vec_req_r,
  output reg  [3:0]  shared_vec_req_r,
  output reg         spi_tx_vec_req_r,
  output reg         uart_b_vec_req_r,
  // watchdog
  output reg         watchdog_start_r,
  output reg         watchdog_refresh_r
);

  // ==========================================================================
  // registers and wires
  reg  [7:0]  global_ctrl_r;
  reg  [7:0]  peripheral_int_enable_reg;
  reg  [7:0]  uart_b_int_enable_reg;
  reg  [7:0]  int_request_flag_reg;
  reg  [3:0]  compare_mode_config;
  reg  [7:0]  flag_nxt;
  reg  [7:0]  rd_byte;
  reg         rd_hit;
  reg         wr_hit;
  wire [3:0]  compare_irq;
  wire [3:0]  periph_evt;
  wire [3:0]  shared_src;
  wire [7:0]  flag_set;
  wire [7:0]  wr_byte;
  wire [9:0]  wr_idx;
  wire [9:0]  rd_idx;
  wire        wr_fire;
  wire        wr_glb;
  wire        wr_per;
  wire        wr_flg;
  wire        wr_uart;
  wire        wr_cfg;
  wire        reload_level;
  wire        reload_fall;
  wire        wd_start;
  wire        wd_refresh;
  wire        wd_running;
  wire        wd_watchdog_start_refresh;
  wire        wd_armed;
  wire        gate;

  // ==========================================================================
  // pin synchroniser for reload input
  iefl_pin_sync u_reload_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (timer2_reload_input),
    .level_r (reload_level),
    .fall_r  (reload_fall)
  );

  // ==========================================================================
  // write decode
  assign wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wready & s_axi_wvalid;
  assign wr_idx  = s_axi_awaddr[11:2];
  assign rd_idx  = s_axi_araddr[11:2];
  assign wr_byte = s_axi_wdata[7:0];
  assign wr_glb  = wr_fire & s_axi_wstrb[0] & (wr_idx == {2'b00, `IEFL_IDX_GLOBAL_CTRL});
  assign wr_per  = wr_fire & s_axi_wstrb[0] & (wr_idx == {2'b00, `IEFL_IDX_PERIPH_EN});
  assign wr_flg  = wr_fire & s_axi_wstrb[0] & (wr_idx == {2'b00, `IEFL_IDX_REQ_FLAG});
  assign wr_uart = wr_fire & s_axi_wstrb[0] & (wr_idx == {2'b00, `IEFL_IDX_UART_B_EN});
  assign wr_cfg  = wr_fire & s_axi_wstrb[0] & (wr_idx == {2'b00, `IEFL_IDX_COMPARE_CFG});

  always @* begin
    case (wr_idx)
      {2'b00, `IEFL_IDX_GLOBAL_CTRL},
      {2'b00, `IEFL_IDX_PERIPH_EN},
      {2'b00, `IEFL_IDX_REQ_FLAG},
      {2'b00, `IEFL_IDX_UART_B_EN},
      {2'b00, `IEFL_IDX_COMPARE_CFG},
      {2'b00, `IEFL_IDX_WDOG_STAT}: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // watchdog start/refresh sequencing
  iefl_wdog_ctl u_wdog (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .wr_arm    (wr_glb & wr_byte[`IEFL_GLB_ARM]),
    .wr_watchdog_start_refresh   (wr_per & wr_byte[`IEFL_BIT_WATCHDOG_START_REFRESH]),
    .wr_other  (wr_fire),
    .start_r   (wd_start),
    .refresh_r (wd_refresh),
    .running_r (wd_running),
    .watchdog_start_refresh_r    (wd_watchdog_start_refresh),
    .armed_r   (wd_armed)
  );

  // ==========================================================================
  // enable and configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      global_ctrl_r             <= `IEFL_RST_BYTE; // RULE20
      peripheral_int_enable_reg <= `IEFL_RST_BYTE;
      uart_b_int_enable_reg     <= `IEFL_RST_BYTE;
      compare_mode_config       <= `IEFL_RST_CFG;
    end else begin
      if (wr_glb)
        global_ctrl_r <= {wr_byte[7:5], 5'h00};
      if (wr_per) // RULE5 RULE6
        peripheral_int_enable_reg <= {wr_byte[7], 1'b0, wr_byte[5:1], 1'b0};
      if (wr_uart) // RULE7
        uart_b_int_enable_reg <= {7'h00, wr_byte[`IEFL_BIT_UART_B]};
      if (wr_cfg) // RULE9
        compare_mode_config <= wr_byte[3:0];
    end
  end

  // ==========================================================================
  // request flag sources
  assign compare_irq = {compare_unit3_irq, compare_unit2_irq,
                        compare_unit1_irq, compare_unit0_irq}; // RULE8
  assign periph_evt  = {adc_pinchange_evt, mac_overflow_evt,
                        i2c_evt, spi_rx_overrun_evt};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_share
      // RULE10 RULE11 RULE12
      assign shared_src[gi] = compare_mode_config[gi] ? compare_irq[gi] : periph_evt[gi];
    end
  endgenerate

  assign flag_set[`IEFL_BIT_T2RELOAD] = reload_fall
                                        & peripheral_int_enable_reg[`IEFL_BIT_T2RELOAD]; // RULE1
  assign flag_set[`IEFL_BIT_T2OV]     = timer2_overflow_evt; // RULE14
  assign flag_set[5:2]                = shared_src; // RULE15
  assign flag_set[`IEFL_BIT_SPITX]    = spi_tx_empty_evt; // RULE16

  // ==========================================================================
  // reserved flag bit never sets
  assign flag_set[0]                  = 1'b0; // RULE16

  // ==========================================================================
  // request flags: write zero clears, set wins over clear
  always @* begin
    flag_nxt = int_request_flag_reg;
    if (wr_flg)
      flag_nxt = int_request_flag_reg & wr_byte; // RULE13
    flag_nxt = flag_nxt | flag_set; // RULE19
    flag_nxt[0] = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn)
      int_request_flag_reg <= `IEFL_RST_BYTE; // RULE20
    else
      int_request_flag_reg <= flag_nxt;
  end

  // ==========================================================================
  // vector requests
  assign gate = global_ctrl_r[`IEFL_GLB_GATE];

  always @(posedge aclk) begin
    if (!aresetn) begin
      timer2_vec_req_r   <= 1'b0;
      shared_vec_req_r   <= 4'h0;
      spi_tx_vec_req_r   <= 1'b0;
      uart_b_vec_req_r   <= 1'b0;
      watchdog_start_r   <= 1'b0;
      watchdog_refresh_r <= 1'b0;
    end else begin
      timer2_vec_req_r <= gate & // RULE17
        ((int_request_flag_reg[`IEFL_BIT_T2RELOAD]
          & peripheral_int_enable_reg[`IEFL_BIT_T2RELOAD])
         | (int_request_flag_reg[`IEFL_BIT_T2OV]
          & global_ctrl_r[`IEFL_GLB_T2OV_EN]));
      shared_vec_req_r <= {4{gate}} & int_request_flag_reg[5:2]
                          & peripheral_int_enable_reg[5:2]; // RULE19
      spi_tx_vec_req_r <= gate & int_request_flag_reg[`IEFL_BIT_SPITX]
                          & peripheral_int_enable_reg[`IEFL_BIT_SPITX];
      uart_b_vec_req_r <= gate & uart_b_req
                          & uart_b_int_enable_reg[`IEFL_BIT_UART_B]; // RULE7
      watchdog_start_r   <= wd_start; // RULE2
      watchdog_refresh_r <= wd_refresh; // RULE3
    end
  end

  // ==========================================================================
  // read mux
  always @* begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      {2'b00, `IEFL_IDX_GLOBAL_CTRL}: rd_byte = global_ctrl_r;
      {2'b00, `IEFL_IDX_PERIPH_EN}:
        rd_byte = peripheral_int_enable_reg | {1'b0, wd_watchdog_start_refresh, 6'h00}; // RULE4
      {2'b00, `IEFL_IDX_REQ_FLAG}:    rd_byte = int_request_flag_reg;
      {2'b00, `IEFL_IDX_UART_B_EN}:   rd_byte = uart_b_int_enable_reg;
      {2'b00, `IEFL_IDX_COMPARE_CFG}: rd_byte = {4'h0, compare_mode_config};
      {2'b00, `IEFL_IDX_WDOG_STAT}:
        rd_byte = {5'h00, reload_level, wd_armed, wd_running};
      // unmapped index reads zero, answered with slave error
      default: rd_hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // axi4-lite handshakes
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IEFL_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `IEFL_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `IEFL_RESP_OKAY : `IEFL_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arready & s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_hit ? `IEFL_RESP_OKAY : `IEFL_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // iefl_top

/* File: logic/iefl_wdog_ctl.v */
// watchdog start/refresh sequencing from register writes
// assumes write strobes are one-cycle pulses from the register slave
`timescale 1ns/1ps
`include "iefl_map.vh"

module iefl_wdog_ctl (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // register write events
  input  wire wr_arm,
  input  wire wr_watchdog_start_refresh,
  input  wire wr_other,
  // watchdog side
  output reg  start_r,
  output reg  refresh_r,
  output reg  running_r,
  output reg  watchdog_start_refresh_r,
  output reg  armed_r
);

  // ========================================================================
  // arm must be the write directly before start/refresh for a refresh; a start needs no arm
  always @(posedge aclk) begin
    if (!aresetn) begin
      start_r   <= 1'b0;
      refresh_r <= 1'b0;
      running_r <= 1'b0;
      watchdog_start_refresh_r    <= 1'b0;
      armed_r   <= 1'b0;
    end else begin
      start_r   <= 1'b0;
      refresh_r <= 1'b0;
      watchdog_start_refresh_r    <= 1'b0; // RULE4
      if (wr_watchdog_start_refresh) begin
        watchdog_start_refresh_r <= 1'b1;
        if (!running_r) begin
          start_r   <= 1'b1; // RULE2
          running_r <= 1'b1;
        end else if (armed_r) begin
          refresh_r <= 1'b1; // RULE3
        end
        armed_r <= 1'b0;
      end else if (wr_arm) begin
        armed_r <= 1'b1;
      end else if (wr_other) begin
        armed_r <= 1'b0; // RULE3
      end
    end
  end

endmodule // iefl_wdog_ctl
